// ==== rtl/skip_sub_pkg.sv ====
// constants and types for the skip and subtract execution block
package skip_sub_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned BIT_SEL_W   = 3;
  localparam int unsigned APB_ADDR_W  = 12;
  // register byte offsets
  localparam logic [11:0] WORK_OFS    = 12'h000;
  localparam logic [11:0] FLAGS_OFS   = 12'h004;
  localparam logic [11:0] STATE_OFS   = 12'h008;
  // flag field positions
  localparam int unsigned BORROW_INV_POS  = 0;
  localparam int unsigned HALF_BORROW_POS = 1;
  localparam int unsigned RESULT_NIL_POS  = 2;
  localparam int unsigned SIGNED_RNG_POS  = 3;
  localparam int unsigned SIGNED_BOR_POS  = 4;
  localparam int unsigned MERGED_NIL_POS  = 5;
  localparam int unsigned FLAGS_W         = 6;
  // reset values
  localparam logic [7:0]  WORK_RST    = 8'h00;
  localparam logic [5:0]  FLAGS_RST   = 6'h00;
  localparam logic [7:0]  NIL_BYTE    = 8'h00;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_SKIP_BIT,
    OP_SKIP_BYTE,
    OP_MINUS_ACCUM,
    OP_MINUS_MEMORY
  } exec_op_t;

  typedef enum {
    ST_EXEC,
    ST_DUMMY
  } exec_state_t;
endpackage

// ==== rtl/skip_and_subtract_exec.sv ====
// execution unit for skip-on-nonzero and subtract instructions with apb access
`timescale 1ns/10ps
`default_nettype none

module skip_and_subtract_exec (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // instruction issue
  input  wire logic                     issue,
  input  wire skip_sub_pkg::exec_op_t   op,
  input  wire logic [2:0]               bit_sel,
  input  wire logic [7:0]               mem_rdata,
  output logic                          issue_ready,
  output logic                          mem_we,
  output logic [7:0]                    mem_wdata,
  output logic                          skip_taken,
  output logic                          dummy_cycle,
  output logic [7:0]                    working_register,
  output logic [5:0]                    status_flags,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  skip_sub_pkg::exec_state_t state_q, state_d;
  logic [7:0]  work_q,   work_d;
  logic [5:0]  flags_q,  flags_d;
  logic        we_q,     we_d;
  logic [7:0]  wdata_q,  wdata_d;
  logic        skip_q,   skip_d;
  logic [31:0] rdata_q,  rdata_d;
  logic        err_q,    err_d;

  logic [8:0]  diff;
  logic [4:0]  low_diff;
  logic [7:0]  res;
  logic        ovf;
  logic        nil;
  logic        fire;
  logic        apb_acc;
  logic        apb_wr;
  logic        known;

  ////////////////////////////////////////////////////////////////////////////
  // subtraction and flag terms
  always_comb
  begin
    diff     = {1'b0, work_q} - {1'b0, mem_rdata};
    // half borrow looks at the low nibble alone
    low_diff = {1'b0, work_q[3:0]} - {1'b0, mem_rdata[3:0]};
    res      = diff[7:0];
    // signed overflow: operand signs differ and the result left the minuend sign
    ovf      = (work_q[7] != mem_rdata[7]) && (res[7] != work_q[7]);
    nil      = (res == skip_sub_pkg::NIL_BYTE);
  end

  // an issue during the dummy cycle is ignored; issue_ready is held low for that cycle
  assign fire        = issue && (state_q == skip_sub_pkg::ST_EXEC);
  assign issue_ready = (state_q == skip_sub_pkg::ST_EXEC);
  assign apb_acc     = psel && penable;
  assign apb_wr      = apb_acc && pwrite;
  // only three word offsets are decoded, the rest are unmapped
  assign known       = (paddr == skip_sub_pkg::WORK_OFS)
                    || (paddr == skip_sub_pkg::FLAGS_OFS)
                    || (paddr == skip_sub_pkg::STATE_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_d = skip_sub_pkg::ST_EXEC;
    work_d  = work_q;
    flags_d = flags_q;
    we_d    = 1'b0;
    wdata_d = wdata_q;
    skip_d  = 1'b0;
    // software writes first, a subtract in the same cycle overrides the fields it updates
    if (apb_wr && (paddr == skip_sub_pkg::WORK_OFS))
    begin
      work_d = pwdata[7:0];
    end
    if (apb_wr && (paddr == skip_sub_pkg::FLAGS_OFS))
    begin
      flags_d = pwdata[5:0];
    end
    if (fire)
    begin
      case (op)
        skip_sub_pkg::OP_SKIP_BIT:
        begin
          skip_d = mem_rdata[bit_sel];
        end
        skip_sub_pkg::OP_SKIP_BYTE:
        begin
          skip_d  = (mem_rdata != skip_sub_pkg::NIL_BYTE);
          we_d    = 1'b1;
          wdata_d = mem_rdata;
        end
        skip_sub_pkg::OP_MINUS_ACCUM,
        skip_sub_pkg::OP_MINUS_MEMORY:
        begin
          if (op == skip_sub_pkg::OP_MINUS_ACCUM)
          begin
            work_d = res;
          end
          else
          begin
            we_d    = 1'b1;
            wdata_d = res;
          end
          // borrow style flags in bits 0 and 1: one means no borrow out of the field
          flags_d[skip_sub_pkg::BORROW_INV_POS]  = ~diff[8];
          flags_d[skip_sub_pkg::HALF_BORROW_POS] = ~low_diff[4];
          flags_d[skip_sub_pkg::RESULT_NIL_POS]  = nil;
          flags_d[skip_sub_pkg::SIGNED_RNG_POS]  = ovf;
          flags_d[skip_sub_pkg::SIGNED_BOR_POS]  = ovf ^ res[7];
          flags_d[skip_sub_pkg::MERGED_NIL_POS]  = nil;
        end
        default:
        begin
          skip_d = 1'b0;
        end
      endcase
    end
    // a taken skip spends one dummy cycle while the next word is fetched
    if (skip_d)
    begin
      state_d = skip_sub_pkg::ST_DUMMY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data
  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = 1'b0;
    // read data is captured in the setup cycle and held through the access
    if (psel && !penable)
    begin
      err_d = !known;
      case (paddr)
        skip_sub_pkg::WORK_OFS:  rdata_d = {24'h000000, work_q};
        skip_sub_pkg::FLAGS_OFS: rdata_d = {26'h0, flags_q};
        skip_sub_pkg::STATE_OFS: rdata_d = {30'h0,
                                            (state_q == skip_sub_pkg::ST_DUMMY), skip_q};
        default:                 rdata_d = skip_sub_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_q <= skip_sub_pkg::ZERO_WORD;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction state registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= skip_sub_pkg::ST_EXEC;
      work_q  <= skip_sub_pkg::WORK_RST;
      flags_q <= skip_sub_pkg::FLAGS_RST;
      we_q    <= 1'b0;
      wdata_q <= skip_sub_pkg::NIL_BYTE;
      skip_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      work_q  <= work_d;
      flags_q <= flags_d;
      we_q    <= we_d;
      wdata_q <= wdata_d;
      skip_q  <= skip_d;
    end
  end

  assign mem_we           = we_q;
  assign mem_wdata        = wdata_q;
  assign skip_taken       = skip_q;
  assign dummy_cycle      = (state_q == skip_sub_pkg::ST_DUMMY);
  assign working_register = work_q;
  assign status_flags     = flags_q;
  assign prdata           = rdata_q;
  // no wait states: every access completes in its first access cycle
  assign pready           = 1'b1;
  // unmapped offsets read zero with an error, writes to them are dropped
  assign pslverr          = apb_acc && err_q;

endmodule // skip_and_subtract_exec

`default_nettype wire

// ==== verif/skip_sub_asserts.sv ====
// concurrent checks for the skip and subtract execution block
`timescale 1ns/10ps
`default_nettype none
module skip_sub_asserts (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   issue,
  input wire skip_sub_pkg::exec_op_t op,
  input wire logic [2:0]             bit_sel,
  input wire logic [7:0]             mem_rdata,
  input wire logic                   issue_ready,
  input wire logic                   mem_we,
  input wire logic [7:0]             mem_wdata,
  input wire logic                   skip_taken,
  input wire logic                   dummy_cycle,
  input wire logic [7:0]             working_register,
  input wire logic [5:0]             status_flags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       take;
  logic       hit;
  logic       ge;
  logic [7:0] diff;
  assign take = issue && issue_ready;
  assign hit  = (op == 2'h0) ? mem_rdata[bit_sel] : (mem_rdata != 8'h00);
  assign ge   = working_register >= mem_rdata;
  assign diff = working_register - mem_rdata;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_skip; take && !op[1] && hit; endsequence
  sequence s_dummy; skip_taken && dummy_cycle && !issue_ready ##1 issue_ready; endsequence
  property p_skip; s_skip |=> s_dummy; endproperty
  a_skip: assert property (p_skip) else $error("skip timing");
  property p_noskip; take && !op[1] && !hit |=> !skip_taken && !dummy_cycle; endproperty
  a_noskip: assert property (p_noskip) else $error("false skip");
  property p_wback; take && op == 2'h1 |=> mem_we && mem_wdata == $past(mem_rdata); endproperty
  a_wback: assert property (p_wback) else $error("no write back");
  property p_noflag; take && !op[1] |=> $stable(status_flags); endproperty
  a_noflag: assert property (p_noflag) else $error("skip moved flags");
  property p_accum; take && op == 2'h2 |=> working_register == $past(diff) && !mem_we; endproperty
  a_accum: assert property (p_accum) else $error("accum diff");
  property p_borrow; take && op[1] |=> status_flags[0] == $past(ge); endproperty
  a_borrow: assert property (p_borrow) else $error("borrow flag");
  property p_nil;
    take && op[1] |=> status_flags[2] == ($past(diff) == 8'h00)
                      && status_flags[5] == status_flags[2];
  endproperty
  a_nil: assert property (p_nil) else $error("nil flags");
  property p_mem; take && op == 2'h3 |=> mem_we && mem_wdata == $past(diff); endproperty
  a_mem: assert property (p_mem) else $error("memory diff");
endmodule // skip_sub_asserts
bind skip_and_subtract_exec skip_sub_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .issue(issue), .op(op), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .issue_ready(issue_ready),
  .mem_we(mem_we), .mem_wdata(mem_wdata), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
  .working_register(working_register), .status_flags(status_flags));
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the skip and subtract execution block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, rst = 1'b1, issue = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  skip_sub_pkg::exec_op_t op = skip_sub_pkg::OP_SKIP_BIT;
  logic [2:0]  bit_sel = 3'h0;
  logic [7:0]  mem_rdata = 8'h00, mem_wdata, working_register;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        issue_ready, mem_we, skip_taken, dummy_cycle, pready, pslverr, err;
  logic [5:0]  status_flags;
  int          error_cnt = 0, checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  skip_and_subtract_exec DUT (.sys_clk(sys_clk), .rst(rst), .issue(issue), .op(op),
    .bit_sel(bit_sel), .mem_rdata(mem_rdata), .issue_ready(issue_ready), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
    .working_register(working_register), .status_flags(status_flags), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  // issue one op, then look at the answer in the following cycle
  task automatic exec(input logic [1:0] o, input logic [2:0] b, input logic [7:0] m,
                      input logic s, input logic we, input logic [7:0] wd);
    int n;
    n = 0;
    while (issue_ready !== 1'b1 && n < 16)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (issue_ready !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
    @(posedge sys_clk);
    issue <= 1'b1;
    op <= skip_sub_pkg::exec_op_t'(o);
    bit_sel <= b;
    mem_rdata <= m;
    @(posedge sys_clk);
    issue <= 1'b0;
    mem_rdata <= ~m;
    @(negedge sys_clk);
    chk({skip_taken, dummy_cycle, issue_ready}, {s, s, !s});
    chk(mem_we, we);
    if (we)
      chk(mem_wdata, wd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    apb(1'b1, skip_sub_pkg::WORK_OFS, 32'h5);
    exec(2'h2, 3'h0, 8'h06, 1'b0, 1'b0, 8'h00);
    chk({working_register, status_flags}, 14'h3FD0);
    exec(2'h3, 3'h0, 8'hFF, 1'b0, 1'b1, 8'h00);
    chk({working_register, status_flags}, 14'h3FE7);
    apb(1'b1, skip_sub_pkg::WORK_OFS, 32'h80);
    exec(2'h3, 3'h0, 8'h01, 1'b0, 1'b1, 8'h7F);
    apb(1'b0, skip_sub_pkg::FLAGS_OFS, 32'h0);
    chk(rd, 32'h19);
    exec(2'h1, 3'h0, 8'h40, 1'b1, 1'b1, 8'h40);
    exec(2'h1, 3'h0, 8'h00, 1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      exec(2'h0, i[2:0], 8'h01 << i[2:0], 1'b1, 1'b0, 8'h00);
      exec(2'h0, i[2:0], ~(8'h01 << i[2:0]), 1'b0, 1'b0, 8'h00);
    end
    chk(status_flags, 6'h19);
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd}, 33'h1_0000_0000);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
